/* File: smp_protect_regs.v */
`timescale 1ns/1ns
`include "smp_regs.vh"

module smp_protect_regs #(
  parameter [7:0] MAKER_CODE = 8'h5a // Arbitrary value
) (
  input wire clk_sys_i,
  input wire srst_i,
  input wire sclk_i,
  input wire cs_n_i,
  input wire si_i,
  output reg so_o,
  output reg so_oe_n_o,
  input wire wp_n_i,
  input wire [2:0] hw_block_select_pins_i,
  input wire hw_top_bottom_pin_i,
  input wire busy_i,
  input wire arr_wr_req_i,
  input wire [`SMP_AW-1:0] arr_addr_i,
  output reg arr_wr_grant_o,
  output reg arr_wr_deny_o,
  output reg [4:0] ext_addr_o,
  output reg [2:0] drive_strength_select_o,
  output reg [3:0] read_latency_select_o,
  output reg write_enable_latch_o
);

  // Two-flop synchronisers for the serial and protection select pins
  reg [6:0] pin_meta_q;
  reg [6:0] pin_sync_q;
  reg sclk_prev_q;
  reg cs_prev_q;

  always @(posedge clk_sys_i) begin
    if (srst_i) begin
      pin_meta_q <= 7'h02;
      pin_sync_q <= 7'h02;
      sclk_prev_q <= 1'b0;
      cs_prev_q <= 1'b1;
    end else begin
      pin_meta_q <= {hw_block_select_pins_i, hw_top_bottom_pin_i, si_i, cs_n_i, sclk_i};
      pin_sync_q <= pin_meta_q;
      sclk_prev_q <= pin_sync_q[0];
      cs_prev_q <= pin_sync_q[1];
    end
  end

  wire sclk_s = pin_sync_q[0];
  wire cs_n_s = pin_sync_q[1];
  wire si_s = pin_sync_q[2];
  // Pins default low, so an open board yields code 000 and no protection
  wire hw_side_s = pin_sync_q[3];
  wire [2:0] hw_bp_s = pin_sync_q[6:4];
  wire sclk_rise = sclk_s & ~sclk_prev_q & ~cs_n_s;
  wire sclk_fall = ~sclk_s & sclk_prev_q & ~cs_n_s;
  wire cs_rise = cs_n_s & ~cs_prev_q;

  reg wp_meta_q;
  reg wp_sync_q;

  always @(posedge clk_sys_i) begin
    if (srst_i) begin
      wp_meta_q <= 1'b1;
      wp_sync_q <= 1'b1;
    end else begin
      wp_meta_q <= wp_n_i;
      wp_sync_q <= wp_meta_q;
    end
  end

  // Register state
  reg wpen_q;
  reg sw_region_side_q;
  reg [2:0] sw_block_select_q;
  reg protection_lock_q;
  reg [1:0] latch_reset_policy_q;
  reg ready_q;

  wire [7:0] status_reg = {wpen_q, 1'b0, sw_region_side_q, sw_block_select_q,
    write_enable_latch_o, 1'b0};
  wire [7:0] config_reg_one = {drive_strength_select_o, 2'b00, protection_lock_q,
    latch_reset_policy_q};
  wire [7:0] config_reg_two = {4'h0, read_latency_select_o};
  wire [7:0] flag_status_reg = {ready_q, 7'h00};
  wire [31:0] ident = {MAKER_CODE, `SMP_ID_IFACE, `SMP_ID_VOLT, `SMP_ID_TEMP,
    `SMP_ID_DENS, `SMP_ID_FREQ};

  // Portion decode: code n protects the span whose top 7-n address bits are
  // all ones (top side) or all zeros (bottom side)
  function prot_hit;
    input [2:0] code;
    input bottom;
    input [`SMP_AW-1:0] addr;
    integer i;
    reg hit;
    begin
      hit = 1'b1;
      if (code == 3'h0) begin
        hit = 1'b0;
      end else begin
        for (i = 0; i < 6; i = i + 1) begin
          if (i < 7 - code) begin
            hit = hit & (addr[`SMP_AW-1-i] ^ bottom);
          end
        end
      end
      prot_hit = hit;
    end
  endfunction

  // Register read data, left aligned for shifting out
  function [31:0] reg_read;
    input [23:0] addr;
    begin
      case (addr)
        `SMP_ADR_STATUS: reg_read = {status_reg, 24'h000000};
        `SMP_ADR_CFG1: reg_read = {config_reg_one, 24'h000000};
        `SMP_ADR_CFG2: reg_read = {config_reg_two, 24'h000000};
        `SMP_ADR_EXT: reg_read = {3'h0, ext_addr_o, 24'h000000};
        `SMP_ADR_FLAG: reg_read = {flag_status_reg, 24'h000000};
        `SMP_ADR_ID: reg_read = ident;
        default: reg_read = 32'h00000000;
      endcase
    end
  endfunction

  // Array write check against both schemes
  wire hw_hit = prot_hit(hw_bp_s, hw_side_s, arr_addr_i);
  wire sw_hit = prot_hit(sw_block_select_q, sw_region_side_q, arr_addr_i);
  wire arr_prot = hw_hit | sw_hit;
  wire arr_latch_ok = (latch_reset_policy_q == `SMP_LRP_SRAM) | write_enable_latch_o;
  wire arr_ok = ~arr_prot & arr_latch_ok;

  // Serial frame state
  reg [6:0] bit_cnt_q;
  reg [31:0] rx_q;
  reg [7:0] cmd_q;
  reg [23:0] addr_q;
  reg [31:0] tx_q;
  reg tx_act_q;
  reg pend_we_q;
  reg [23:0] pend_addr_q;
  reg [7:0] pend_data_q;
  reg arr_seen_q;

  wire [6:0] cnt_n = bit_cnt_q + 7'd1;
  wire [31:0] rx_n = {rx_q[30:0], si_s};
  wire [7:0] cmd_n = rx_n[7:0];
  wire [23:0] rd_addr = (cnt_n == `SMP_BITS_ADDR) ? rx_n[23:0] : addr_q;
  wire [6:0] reg_rd_load = `SMP_BITS_ADDR + {3'h0, read_latency_select_o};
  wire reg_wr_ok = write_enable_latch_o & (~wpen_q | wp_sync_q);

  always @(posedge clk_sys_i) begin
    if (srst_i) begin
      bit_cnt_q <= 7'd0;
      rx_q <= 32'h00000000;
      cmd_q <= 8'h00;
      addr_q <= 24'h000000;
      tx_q <= 32'h00000000;
      tx_act_q <= 1'b0;
      pend_we_q <= 1'b0;
      pend_addr_q <= 24'h000000;
      pend_data_q <= 8'h00;
      so_o <= 1'b0;
      so_oe_n_o <= 1'b1;
    end else if (cs_n_s) begin
      bit_cnt_q <= 7'd0;
      cmd_q <= 8'h00;
      tx_act_q <= 1'b0;
      pend_we_q <= 1'b0;
      so_oe_n_o <= 1'b1;
    end else begin
      if (sclk_rise) begin
        rx_q <= rx_n;
        if (bit_cnt_q != 7'h7f) begin
          bit_cnt_q <= cnt_n;
        end
        if (cnt_n == `SMP_BITS_CMD) begin
          cmd_q <= cmd_n;
          case (cmd_n)
            `SMP_OP_RDSR: begin
              tx_q <= {status_reg, 24'h000000};
              tx_act_q <= 1'b1;
            end
            `SMP_OP_RDFSR: begin
              tx_q <= {flag_status_reg, 24'h000000};
              tx_act_q <= 1'b1;
            end
            `SMP_OP_RDID: begin
              tx_q <= ident;
              tx_act_q <= 1'b1;
            end
            default: begin
              tx_act_q <= 1'b0;
            end
          endcase
        end
        if (cnt_n == `SMP_BITS_ADDR) begin
          addr_q <= rx_n[23:0];
        end
        if (cmd_q == `SMP_OP_REG_READ && cnt_n == reg_rd_load) begin
          tx_q <= reg_read(rd_addr);
          tx_act_q <= 1'b1;
        end
        if (cmd_q == `SMP_OP_WRSR && cnt_n == `SMP_BITS_WRSR) begin
          pend_we_q <= 1'b1;
          pend_addr_q <= `SMP_ADR_STATUS;
          pend_data_q <= rx_n[7:0];
        end
        if (cmd_q == `SMP_OP_REG_WRITE && cnt_n == `SMP_BITS_REGISTER_WRITE_CMD) begin
          pend_we_q <= 1'b1;
          pend_addr_q <= addr_q;
          pend_data_q <= rx_n[7:0];
        end
      end
      if (sclk_fall && tx_act_q) begin
        so_o <= tx_q[31];
        so_oe_n_o <= 1'b0;
        tx_q <= {tx_q[30:0], 1'b0};
      end
    end
  end

  wire reg_frame = (cmd_q == `SMP_OP_WRSR) | (cmd_q == `SMP_OP_REG_WRITE);
  wire do_wr = cs_rise & pend_we_q & reg_wr_ok;

  always @(posedge clk_sys_i) begin
    if (srst_i) begin
      wpen_q <= 1'b0;
      sw_region_side_q <= 1'b0;
      sw_block_select_q <= 3'h0;
      protection_lock_q <= 1'b0;
      latch_reset_policy_q <= `SMP_RST_LRP;
      drive_strength_select_o <= `SMP_RST_DS;
      read_latency_select_o <= `SMP_RST_LAT;
      ext_addr_o <= `SMP_RST_EXT;
      write_enable_latch_o <= 1'b0;
      ready_q <= 1'b1;
      arr_seen_q <= 1'b0;
      arr_wr_grant_o <= 1'b0;
      arr_wr_deny_o <= 1'b0;
    end else begin
      ready_q <= ~busy_i;
      arr_wr_grant_o <= arr_wr_req_i & arr_ok;
      arr_wr_deny_o <= arr_wr_req_i & ~arr_ok;
      if (do_wr) begin
        case (pend_addr_q)
          `SMP_ADR_STATUS: begin
            wpen_q <= pend_data_q[`SMP_STAT_WPEN];
            if (!protection_lock_q) begin
              sw_region_side_q <= pend_data_q[`SMP_STAT_SIDE];
              sw_block_select_q <= pend_data_q[`SMP_STAT_BP_HI:`SMP_STAT_BP_LO];
            end
          end
          `SMP_ADR_CFG1: begin
            drive_strength_select_o <= pend_data_q[`SMP_CFG1_DS_HI:`SMP_CFG1_DS_LO];
            protection_lock_q <= pend_data_q[`SMP_CFG1_LOCK];
            latch_reset_policy_q <= pend_data_q[`SMP_CFG1_LRP_HI:`SMP_CFG1_LRP_LO];
          end
          `SMP_ADR_CFG2: begin
            read_latency_select_o <= pend_data_q[`SMP_CFG2_LAT_HI:`SMP_CFG2_LAT_LO];
          end
          `SMP_ADR_EXT: begin
            ext_addr_o <= pend_data_q[`SMP_EXT_HI:0];
          end
          default: begin
            ext_addr_o <= ext_addr_o;
          end
        endcase
      end
      // Reads never touch the segment register, even past a segment end
      // A grant in the same cycle as the frame end is kept for the next frame
      if (arr_wr_req_i && arr_ok) begin
        arr_seen_q <= 1'b1;
      end else if (cs_rise) begin
        arr_seen_q <= 1'b0;
      end
      if (cs_rise) begin
        if (cmd_q == `SMP_OP_WR_ENABLE) begin
          write_enable_latch_o <= 1'b1;
        end else if (cmd_q == `SMP_OP_WR_DISABLE) begin
          write_enable_latch_o <= 1'b0;
        end else if (reg_frame) begin
          write_enable_latch_o <= 1'b0;
        end else if (arr_seen_q && latch_reset_policy_q != `SMP_LRP_B2B &&
                     latch_reset_policy_q != `SMP_LRP_SRAM) begin
          write_enable_latch_o <= 1'b0;
        end
      end
    end
  end

endmodule

/* File: smp_regs.vh */
`ifndef SMP_REGS_VH
`define SMP_REGS_VH

// Register addresses used by the register read and register write instructions
`define SMP_ADR_STATUS 24'h000000
`define SMP_ADR_CFG1 24'h000002
`define SMP_ADR_CFG2 24'h000003
`define SMP_ADR_EXT 24'h000009
`define SMP_ADR_FLAG 24'h00000a
`define SMP_ADR_ID 24'h000030

// Instruction opcodes
`define SMP_OP_WR_ENABLE 8'h06
`define SMP_OP_WR_DISABLE 8'h04
`define SMP_OP_RDSR 8'h05
`define SMP_OP_WRSR 8'h01
`define SMP_OP_RDFSR 8'h70
`define SMP_OP_RDID 8'h9f
`define SMP_OP_REG_READ 8'h65
`define SMP_OP_REG_WRITE 8'h71

// Status register fields
`define SMP_STAT_WPEN 7
`define SMP_STAT_SIDE 5
`define SMP_STAT_BP_HI 4
`define SMP_STAT_BP_LO 2
`define SMP_STAT_WEL 1

// Configuration register 1 fields
`define SMP_CFG1_DS_HI 7
`define SMP_CFG1_DS_LO 5
`define SMP_CFG1_LOCK 2
`define SMP_CFG1_LRP_HI 1
`define SMP_CFG1_LRP_LO 0

// Configuration register 2, flag register and segment register fields
`define SMP_CFG2_LAT_HI 3
`define SMP_CFG2_LAT_LO 0
`define SMP_FSR_READY 7
`define SMP_EXT_HI 4

// Reset values
`define SMP_RST_DS 3'h3
`define SMP_RST_LRP 2'h0
`define SMP_RST_LAT 4'h0
`define SMP_RST_EXT 5'h00

// Latch reset policy codes
`define SMP_LRP_NORMAL 2'h0
`define SMP_LRP_SRAM 2'h1
`define SMP_LRP_B2B 2'h2

// Identification fields below the maker code
`define SMP_ID_IFACE 4'h2
`define SMP_ID_VOLT 4'h1
`define SMP_ID_TEMP 4'h2
`define SMP_ID_DENS 4'h8
`define SMP_ID_FREQ 8'h01

// Frame bit counts: command, command plus address, register data ends
`define SMP_BITS_CMD 7'd8
`define SMP_BITS_WRSR 7'd16
`define SMP_BITS_ADDR 7'd32
`define SMP_BITS_REGISTER_WRITE_CMD 7'd40

// Die array address width
`define SMP_AW 27

`endif

/* File: smp_protect_regs_asserts.sv */
`timescale 1ns/1ns
module smp_chk (
  input wire clk_sys_i,
  input wire srst_i,
  input wire cs_n_i,
  input wire [2:0] hw_block_select_pins_i,
  input wire hw_top_bottom_pin_i,
  input wire arr_wr_req_i,
  input wire [26:0] arr_addr_i,
  input wire arr_wr_grant_o,
  input wire arr_wr_deny_o,
  input wire [4:0] ext_addr_o,
  input wire [2:0] drive_strength_select_o,
  input wire [3:0] read_latency_select_o,
  input wire write_enable_latch_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (srst_i);
  wire [3:0] pins = {hw_block_select_pins_i, hw_top_bottom_pin_i};
  wire [11:0] cfg = {ext_addr_o, drive_strength_select_o, read_latency_select_o};
  sequence s_req;
    arr_wr_req_i;
  endsequence
  sequence s_ans;
    ##1 (arr_wr_grant_o ^ arr_wr_deny_o);
  endsequence
  // Pins held past the synchroniser depth before the request
  property p_hw(c, hit);
    s_req ##0 (pins == c && $past(pins, 2) == c && $past(pins, 3) == c && hit)
      |=> arr_wr_deny_o;
  endproperty
  a_req_answer: assert property (s_req |-> s_ans)
    else $error("Array request not answered once");
  a_no_stray: assert property (!arr_wr_req_i |=> !arr_wr_grant_o && !arr_wr_deny_o)
    else $error("Array answer without request");
  a_hw_all: assert property (p_hw(4'b1110, 1'b1))
    else $error("Whole array pin code not denied");
  a_hw_top: assert property (p_hw(4'b0010, arr_addr_i[26:21] == 6'h3f))
    else $error("Top pin span not denied");
  a_hw_bottom: assert property (p_hw(4'b0011, arr_addr_i[26:21] == 6'h00))
    else $error("Bottom pin span not denied");
  a_latch_at_cs: assert property ($changed(write_enable_latch_o) |-> $past(cs_n_i) && cs_n_i)
    else $error("Latch changed inside a frame");
  a_cfg_at_cs: assert property (!$stable(cfg) |-> $past(cs_n_i) && cs_n_i)
    else $error("Register outputs changed inside a frame");
  a_reset_vals: assert property ($fell(srst_i) |-> cfg == 12'h030 && !write_enable_latch_o)
    else $error("Wrong values after reset");
endmodule

bind smp_protect_regs smp_chk smp_chk_i (
  .clk_sys_i, .srst_i, .cs_n_i, .hw_block_select_pins_i, .hw_top_bottom_pin_i,
  .arr_wr_req_i, .arr_addr_i, .arr_wr_grant_o, .arr_wr_deny_o, .ext_addr_o,
  .drive_strength_select_o, .read_latency_select_o, .write_enable_latch_o
);

/* File: smp_spi_host.sv */
`timescale 1ns/1ns
module smp_spi_host (
  input wire clk_i,
  input wire so_i,
  output reg sclk_o,
  output reg cs_n_o,
  output reg si_o
);
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    si_o = 1'b0;
  end
  // Deselected data line toggles so a stale level is never trusted
  task automatic sel(input bit on);
    @(posedge clk_i) begin
      cs_n_o <= !on;
      if (!on) si_o <= ~si_o;
    end
    repeat (8) @(posedge clk_i);
  endtask
  // Sends n bits, idles nd dummy bits, then shifts in nin bits
  task automatic frame(input [63:0] tx, input int n, input int nd, input int nin,
                       output [31:0] rx);
    rx = '0;
    sel(1);
    for (int i = 0; i < n + nd + nin; i++) begin
      @(posedge clk_i) si_o <= (i < n) ? tx[n - 1 - i] : ~si_o;
      repeat (7) @(posedge clk_i);
      if (i >= n + nd) rx = {rx[30:0], so_i};
      sclk_o <= 1'b1;
      repeat (8) @(posedge clk_i);
      sclk_o <= 1'b0;
    end
    sel(0);
  endtask
endmodule

/* File: testbench.sv */
`timescale 1ns/1ns
`include "smp_regs.vh"
module testbench;
  localparam [7:0] MAKER = 8'h3c; // Arbitrary value
  reg clk_sys_i = 1'b0;
  reg srst_i = 1'b1;
  reg wp_n = 1'b1;
  reg [2:0] hwp = 3'h0;
  reg hwtb = 1'b0;
  reg busy = 1'b0;
  reg req = 1'b0;
  reg [26:0] addr = 27'h0;
  wire sclk, cs_n, si, so, grant, deny, wel;
  wire so_oe_n;
  // Released data line shows the inverse of its last level
  wire so_line = so_oe_n ? ~so : so;
  wire [4:0] ext;
  wire [2:0] ds;
  wire [3:0] lat;
  logic [31:0] rx;
  int err_count = 0;
  int checks = 0;
  int cyc = 0;
  int dly = 0;
  always #5 clk_sys_i = ~clk_sys_i;
  smp_protect_regs #(.MAKER_CODE(MAKER)) smp_protect_regs_i (
    .clk_sys_i, .srst_i, .sclk_i(sclk), .cs_n_i(cs_n), .si_i(si), .so_o(so),
    .so_oe_n_o(so_oe_n),
    .wp_n_i(wp_n), .hw_block_select_pins_i(hwp), .hw_top_bottom_pin_i(hwtb), .busy_i(busy),
    .arr_wr_req_i(req), .arr_addr_i(addr), .arr_wr_grant_o(grant), .arr_wr_deny_o(deny),
    .ext_addr_o(ext), .drive_strength_select_o(ds), .read_latency_select_o(lat),
    .write_enable_latch_o(wel));
  smp_spi_host smp_spi_host_i (
    .clk_i(clk_sys_i), .so_i(so_line), .sclk_o(sclk), .cs_n_o(cs_n), .si_o(si));
  task automatic final_report;
    $display("Checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_count++;
      final_report;
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmd(input [7:0] op);
    smp_spi_host_i.frame({56'h0, op}, 8, 0, 0, rx);
  endtask
  task automatic wr(input bit en, input [39:0] tx, input int n);
    if (en) cmd(`SMP_OP_WR_ENABLE);
    smp_spi_host_i.frame({24'h0, tx}, n, 0, 0, rx);
  endtask
  task automatic wr_reg(input bit en, input [23:0] a, input [7:0] d);
    wr(en, {`SMP_OP_REG_WRITE, a, d}, 40);
  endtask
  task automatic wrsr(input bit en, input [7:0] d);
    wr(en, {24'h0, `SMP_OP_WRSR, d}, 16);
  endtask
  task automatic q(input string what, input [31:0] tx, input int n, input int nin,
                   input [31:0] exp);
    smp_spi_host_i.frame({32'h0, tx}, n, (n == 32) ? dly : 0, nin, rx);
    chk(what, exp, rx);
  endtask
  task automatic arr(input [26:0] a, input bit g);
    @(posedge clk_sys_i) begin
      req <= 1'b1;
      addr <= a;
    end
    @(posedge clk_sys_i) req <= 1'b0;
    #1 chk("grant", g, grant);
    chk("deny", !g, deny);
  endtask
  function automatic bit prot(input int n, input bit b, input [26:0] a);
    longint sz = 64'd1 << (20 + n);
    if (n == 0) return 0;
    if (n == 7) return 1;
    return b ? (a < sz) : (a >= (64'd1 << 27) - sz);
  endfunction
  task automatic t_reset;
    chk("ds", 3'h3, ds);
    chk("wel", 1'b0, wel);
    q("sr", {`SMP_OP_REG_READ, `SMP_ADR_STATUS}, 32, 8, 8'h00);
    q("cr1", {`SMP_OP_REG_READ, `SMP_ADR_CFG1}, 32, 8, 8'h60);
    q("cr2", {`SMP_OP_REG_READ, `SMP_ADR_CFG2}, 32, 8, 8'h00);
    q("ext", {`SMP_OP_REG_READ, `SMP_ADR_EXT}, 32, 8, 8'h00);
    q("flag", {`SMP_OP_REG_READ, `SMP_ADR_FLAG}, 32, 8, 8'h80);
    q("id", {`SMP_OP_REG_READ, `SMP_ADR_ID}, 32, 32, {MAKER, 24'h212801});
    q("id op", `SMP_OP_RDID, 8, 32, {MAKER, 24'h212801});
    q("gap", {`SMP_OP_REG_READ, 24'h000001}, 32, 8, 8'h00);
  endtask
  task automatic t_latch;
    wr_reg(0, `SMP_ADR_EXT, 8'hff);
    chk("ext nowel", 5'h00, ext);
    cmd(`SMP_OP_WR_ENABLE);
    chk("wel set", 1'b1, wel);
    q("sr wel", `SMP_OP_RDSR, 8, 8, 8'h02);
    wr_reg(0, `SMP_ADR_EXT, 8'hff);
    chk("ext", 5'h1f, ext);
    chk("wel clr", 1'b0, wel);
    q("ext rd", {`SMP_OP_REG_READ, `SMP_ADR_EXT}, 32, 8, 8'h1f);
  endtask
  task automatic t_wp;
    wrsr(1, 8'h80);
    @(posedge clk_sys_i) wp_n <= 1'b0;
    wrsr(1, 8'h9c);
    q("sr wp", `SMP_OP_RDSR, 8, 8, 8'h80);
    @(posedge clk_sys_i) wp_n <= 1'b1;
    wrsr(1, 8'h5f);
    q("sr rsvd", `SMP_OP_RDSR, 8, 8, 8'h1c);
    wr_reg(1, `SMP_ADR_CFG1, 8'h04);
    chk("ds lock", 3'h0, ds);
    wrsr(1, 8'h20);
    q("sr lock", `SMP_OP_RDSR, 8, 8, 8'h1c);
    wr_reg(1, `SMP_ADR_CFG1, 8'h61);
    wr_reg(1, `SMP_ADR_CFG2, 8'hff);
    chk("lat", 4'hf, lat);
    dly = 15;
    q("cr2 rd", {`SMP_OP_REG_READ, `SMP_ADR_CFG2}, 32, 8, 8'h0f);
    @(posedge clk_sys_i) busy <= 1'b1;
    q("flag busy", `SMP_OP_RDFSR, 8, 8, 8'h00);
    @(posedge clk_sys_i) busy <= 1'b0;
  endtask
  // SRAM-like policy active: only the protected spans may refuse
  task automatic t_protect;
    longint sz;
    logic [26:0] a;
    // Clear the whole-array software span left by the previous scenario
    wrsr(1, 8'h00);
    for (int m = 0; m < 32; m++) begin
      @(posedge clk_sys_i) begin
        hwp <= m[4] ? 3'h0 : m[2:0];
        hwtb <= m[3];
      end
      wrsr(m[4], {2'b00, m[3], m[2:0], 2'b00});
      sz = 64'd1 << (20 + m[2:0]);
      for (int k = 0; k < 4; k++) begin
        a = k[1] ? 28'h8000000 - sz - k[0] : sz - 1 + k[0];
        arr(a, !prot(m[2:0], m[3], a));
      end
    end
    wrsr(1, 8'h24);
    @(posedge clk_sys_i) begin
      hwp <= 3'h1;
      hwtb <= 1'b0;
    end
    repeat (4) @(posedge clk_sys_i);
    arr(27'h0, 1'b0);
    arr(27'h7ffffff, 1'b0);
    arr(27'h4000000, 1'b1);
  endtask
  task automatic t_policy;
    for (int p = 0; p < 4; p++) begin
      if (p == 1) continue;
      wr_reg(1, `SMP_ADR_CFG1, {6'h18, p[1:0]});
      arr(27'h4000000, 1'b0);
      cmd(`SMP_OP_WR_ENABLE);
      smp_spi_host_i.sel(1);
      arr(27'h4000001, 1'b1);
      arr(27'h4000002, 1'b1);
      smp_spi_host_i.sel(0);
      arr(27'h4000003, p == 2);
      if (p == 2) begin
        cmd(`SMP_OP_WR_DISABLE);
        arr(27'h4000004, 1'b0);
      end
    end
  endtask
  initial begin
    repeat (4) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    repeat (8) @(posedge clk_sys_i);
    t_reset;
    t_latch;
    t_wp;
    t_protect;
    t_policy;
    final_report;
  end
endmodule
